/* bench/tss_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tss_host (
   // clock
   input  wire logic        clk,
   // write channels
   output logic [5:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   // read channels
   output logic [5:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
      bready = 1'b1;
      rready = 1'b1;
   end
   // ----
   // bus cycles: ready sampled mid-cycle, acted on at the next edge
   // ----
   task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(negedge clk);
         ta = awready & awvalid;
         tw = wready & wvalid;
         tb = bvalid;
         r  = bresp;
         @(posedge clk);
         if (ta) begin
            awvalid <= 1'b0;
            awaddr  <= ~a;
         end
         if (tw) begin
            wvalid <= 1'b0;
            wdata  <= ~d;
         end
      end while (!tb);
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge clk);
         ta = arready & arvalid;
         tr = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge clk);
         if (ta) begin
            arvalid <= 1'b0;
            araddr  <= ~a;
         end
      end while (!tr);
   endtask : rd
endmodule : tss_host
`default_nettype wire

/* bench/tss_trigger_select_tb.sv */
`include "tss_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tss_trigger_select_tb
   import tss_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        extTrigPin = 1'b1;
   logic [3:0]  levelAbove = 4'h0;
   logic [7:0]  syncLineIn = 8'hff;
   logic        selfTestFault = 1'b0;
   logic        trigOut, armedOut;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv, lim;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          fail_count = 0;
   int          checks = 0;
   int          fires = 0;
   int          cyc = 0;

   tss_trigger_select #(.NUM_CH(4)) dut (
      .clk(clk), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .extTrigPin(extTrigPin), .levelAbove(levelAbove), .syncLineIn(syncLineIn),
      .selfTestFault(selfTestFault), .trigOut(trigOut), .armedOut(armedOut)
   );
   tss_host host (
      .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   // ----
   // helpers
   // ----
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic rc(input string n, input logic [5:0] a, input logic [31:0] exp);
      host.rd(a, rv, resp);
      chk(n, rv, exp);
   endtask : rc
   task automatic cmd(input int b);
      host.wr(`TSS_A_CTRL, 32'h1 << b, resp);
   endtask : cmd
   task automatic ssel(input logic [1:0] s, input logic [2:0] i, input tss_kind_t k);
      host.wr(`TSS_A_SRC, {24'h0, s, i, k}, resp);
   endtask : ssel
   function automatic logic [31:0] srcv(input logic two, input logic [2:0] i, input tss_kind_t k);
      return {24'h0, two, 1'b0, i, k};
   endfunction : srcv
   task automatic fired(input int e);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("fires", fires, e);
      fires = 0;
      @(posedge clk);
   endtask : fired
   task automatic armed(input logic e);
      @(negedge clk);
      chk("armed", armedOut, e);
      @(posedge clk);
   endtask : armed
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (trigOut === 1'b1)
         fires++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   // ----
   // tests
   // ----
   initial begin
      int n, m, p;
      logic s;
      void'($urandom(32'h12a6a107));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rc("src1", `TSS_A_SRC, srcv(0, 0, TSS_IMM));
      rc("slope", `TSS_A_SLOPE, 32'h3);
      host.rd(6'h28, rv, resp);
      chk("rresp", resp, `TSS_RESP_ERR);
      host.wr(6'h28, 32'h1, resp);
      chk("bresp", resp, `TSS_RESP_ERR);
      fired(0);
      armed(0);
      cmd(`TSS_C_ARM);
      fired(1);
      ssel(2, 0, TSS_HOLD);
      rc("src2", `TSS_A_SRC, srcv(1, 0, TSS_HOLD));
      $display("test reset done");
      host.wr(`TSS_A_ESE, 32'h18, resp);
      for (n = `TSS_C_TRG; n <= `TSS_C_GET; n++) begin
         cmd(n);
         rc("err", `TSS_A_ERR, 32'h1);
         cmd(`TSS_C_CLS);
         rc("err", `TSS_A_ERR, 32'h0);
      end
      rc("stat", `TSS_A_STAT, 32'h0);
      rc("mask", `TSS_A_ESE, 32'h18);
      $display("test ignored done");
      ssel(0, 0, TSS_BUS);
      cmd(`TSS_C_ARM);
      fired(0);
      cmd(`TSS_C_TRG);
      fired(1);
      rc("err", `TSS_A_ERR, 32'h0);
      ssel(0, 0, TSS_EXT);
      extTrigPin <= 1'b0;
      cmd(`TSS_C_ARM);
      extTrigPin <= 1'b1;
      fired(0);
      extTrigPin <= 1'b0;
      fired(1);
      $display("test bus and external done");
      for (n = 1; n <= 4; n++) begin
         s = 1'($urandom);
         lim = $urandom & 32'hff;
         host.wr(`TSS_A_LIMIT, lim, resp);
         host.wr(`TSS_A_SLOPE, {31'h1, s}, resp);
         levelAbove <= {4{~s}};
         ssel(0, 3'(n), TSS_INT);
         rc("limit", `TSS_A_LIMIT, lim & ~(32'h11 << (n - 1)));
         rc("src1", `TSS_A_SRC, srcv(0, (n == 1) ? 3'h0 : 3'(n), TSS_INT));
         cmd(`TSS_C_ARM);
         levelAbove[n % 4] <= s;
         fired(0);
         levelAbove[n - 1] <= s;
         fired(1);
      end
      $display("test internal done");
      ssel(0, 5, TSS_INT);
      rc("err", `TSS_A_ERR, 32'h8);
      rc("src1", `TSS_A_SRC, srcv(0, 4, TSS_INT));
      cmd(`TSS_C_CLS);
      ssel(0, 0, TSS_HOLD);
      cmd(`TSS_C_ARM);
      armed(1);
      ssel(0, 0, TSS_EXT);
      rc("err", `TSS_A_ERR, 32'h4);
      rc("src1", `TSS_A_SRC, srcv(0, 0, TSS_HOLD));
      extTrigPin <= 1'b1;
      @(posedge clk);
      extTrigPin <= 1'b0;
      fired(0);
      cmd(`TSS_C_ABORT);
      ssel(2, 0, TSS_BUS);
      cmd(`TSS_C_ARM);
      cmd(`TSS_C_TRG);
      fired(1);
      $display("test refusal and hold done");
      for (m = 1; m <= 2; m++) begin
         p = 2 * ($urandom % 4);
         cmd(`TSS_C_CLS);
         ssel(1, 0, TSS_EXT);
         rc("src1", `TSS_A_SRC, srcv(0, 0, TSS_EXT));
         host.wr(`TSS_A_MODE, (p << 2) | m, resp);
         rc("src1", `TSS_A_SRC, srcv(0, 3'(p + 1), TSS_LINE));
         ssel(0, 0, TSS_BUS);
         chk("bresp", resp, `TSS_RESP_OK);
         rc("err", `TSS_A_ERR, 32'h2);
         rc("src1", `TSS_A_SRC, srcv(0, 3'(p + 1), TSS_LINE));
         ssel(2, 0, TSS_EXT);
         rc("src2", `TSS_A_SRC, srcv(1, 0, TSS_EXT));
         cmd(`TSS_C_ARM);
         syncLineIn[p] <= 1'b0;
         fired(0);
         syncLineIn[p + 1] <= 1'b0;
         fired(1);
         syncLineIn <= 8'hff;
         host.wr(`TSS_A_MODE, 32'h0, resp);
      end
      $display("test master and slave done");
      for (n = 0; n < 2; n++) begin
         selfTestFault <= n[0];
         cmd(`TSS_C_CLS);
         cmd(`TSS_C_TEST);
         rc("test", `TSS_A_TEST, n);
         rc("err", `TSS_A_ERR, n << 4);
      end
      $display("test self test done");
      wrap_up();
   end
endmodule : tss_trigger_select_tb
`default_nettype wire

/* logic/tss_consts.svh */
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
// register byte addresses
`define TSS_A_CTRL  6'h00
`define TSS_A_SRC   6'h04
`define TSS_A_SLOPE 6'h08
`define TSS_A_MODE  6'h0c
`define TSS_A_LIMIT 6'h10
`define TSS_A_ERR   6'h14
`define TSS_A_STAT  6'h18
`define TSS_A_ESE   6'h1c
`define TSS_A_TEST  6'h20
// control command bits
`define TSS_C_ARM   0
`define TSS_C_ABORT 1
`define TSS_C_TRG   2
`define TSS_C_GET   3
`define TSS_C_CLS   4
`define TSS_C_TEST  5
// error bits
`define TSS_E_IGN   0
`define TSS_E_CONF  1
`define TSS_E_ARMD  2
`define TSS_E_RANGE 3
`define TSS_E_TEST  4
// event and status byte bits
`define TSS_EV_DEV  3
`define TSS_EV_EXE  4
`define TSS_SB_ERR  2
`define TSS_SB_ESB  5
`define TSS_SB_OPER 7
// reset values and codes
`define TSS_SLOPE_RST 2'h3
`define TSS_IDX_NONE  3'h0
`define TSS_IDX_ONE   3'h1
`define TSS_SEL_TWO   2'h2
`define TSS_RESP_OK   2'h0
`define TSS_RESP_ERR  2'h2
`endif

/* logic/tss_pkg.sv */
package tss_pkg;
   typedef enum logic [2:0] {
      TSS_BUS, TSS_EXT, TSS_HOLD, TSS_IMM, TSS_INT, TSS_LINE
   } tss_kind_t;
   typedef enum logic [1:0] {
      TSS_NORMAL, TSS_MASTER, TSS_SLAVE
   } tss_mode_t;
   typedef enum logic {TSS_IDLE, TSS_WAIT} tss_arm_t;
   typedef struct packed {
      tss_kind_t  kind;
      logic [2:0] idx;
   } tss_src_t;
endpackage : tss_pkg

/* logic/tss_trigger_select.sv */
// Behaviour
// - two trigger selectors, both shared by all channels.
// - source command or query without selector index targets selector one.
// - selecting a source does not arm; arm command enters wait state.
// - external source fires on each falling edge of the trigger pin.
// - instant source fires at once, only once armed.
// - bus trigger or group trigger while not waiting is dropped, error logged.
// - armed with bus source, bus trigger command fires.
// - internal n fires on channel n level; n limited by channel count.
// - slope positive fires rising above level, negative falling below.
// - selecting internal n clears limit-test enables of channel n.
// - master or slave mode forces selector one onto the pair trigger line.
// - selector one changes in master or slave mode while not armed give settings conflict.
// - selector two keeps value and stays writable in any mode.
// - source commands are refused while armed; a master or slave mode write still forces selector one.
// - reset gives selector one instant, selector two hold.
// - query reports kind and index; internal channel one index reads zero.
// - hold source never fires.
// - status clear empties event, operation, error state and summary bits.
// - status clear keeps the enable masks.
// - self test returns zero on pass, non-zero on fail, logs error.
// - line pairs 0,2,4,6; even line samples, next odd line triggers.
`include "tss_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tss_trigger_select
   import tss_pkg::*;
#(
   parameter int NUM_CH = 4
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // axi4-lite write
   input  wire logic [5:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [5:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // trigger inputs
   input  wire logic              extTrigPin,
   input  wire logic [NUM_CH-1:0] levelAbove,
   input  wire logic [7:0]        syncLineIn,
   input  wire logic              selfTestFault,
   // trigger outputs
   output logic                   trigOut,
   output logic                   armedOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic        awHeld_q, wHeld_q, bvalid_q, rvalid_q;
   logic [5:0]  awAddr_q;
   logic [31:0] wData_q, rdata_q, rdNext;
   logic [3:0]  wStrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic        wrEn, rdMapped, wrMapped;

   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready  = !wHeld_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign wrEn = awHeld_q && wHeld_q && !bvalid_q && wStrb_q[0];

   always_comb begin
      case (awAddr_q)
         `TSS_A_CTRL, `TSS_A_SRC, `TSS_A_SLOPE, `TSS_A_MODE,
         `TSS_A_LIMIT, `TSS_A_ESE: wrMapped = 1'b1;
         default:                   wrMapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= `TSS_RESP_OK;
         awAddr_q <= '0;
         wData_q  <= '0;
         wStrb_q  <= '0;
      end else begin
         if (s_axi_awvalid && !awHeld_q) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeld_q) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (awHeld_q && wHeld_q && !bvalid_q) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wrMapped ? `TSS_RESP_OK : `TSS_RESP_ERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   tss_src_t    sel_q [2];
   tss_mode_t   mode_q;
   tss_arm_t    state_q;
   tss_src_t    newSrc;
   logic [7:0]  d;
   logic        cmd, armed, busCmd, clrCmd, testCmd;
   logic        srcWr, srcSel, srcValid, srcOk, srcConf, srcArmd, srcBad;
   logic        modeWr, modeOk, qSel_q;

   assign d       = wData_q[7:0];
   assign armed   = state_q == TSS_WAIT;
   assign cmd     = wrEn && awAddr_q == `TSS_A_CTRL;
   assign busCmd  = cmd && (d[`TSS_C_TRG] || d[`TSS_C_GET]);
   assign clrCmd  = cmd && d[`TSS_C_CLS];
   assign testCmd = cmd && d[`TSS_C_TEST];
   assign srcWr   = wrEn && awAddr_q == `TSS_A_SRC;
   assign srcSel  = d[7:6] == `TSS_SEL_TWO;
   assign newSrc = '{kind: tss_kind_t'(d[2:0]),
                     idx: (d[2:0] == TSS_INT && d[5:3] == `TSS_IDX_NONE) ? `TSS_IDX_ONE : d[5:3]};

   always_comb begin
      case (newSrc.kind)
         TSS_BUS, TSS_EXT, TSS_HOLD, TSS_IMM: srcValid = 1'b1;
         TSS_INT:  srcValid = 32'(newSrc.idx) <= NUM_CH;
         TSS_LINE: srcValid = 1'b1;
         default:  srcValid = 1'b0;
      endcase
      if (d[7:6] == 2'h3)
         srcValid = 1'b0;
   end

   assign srcArmd = srcWr && armed;
   assign srcConf = srcWr && !armed && !srcSel && mode_q != TSS_NORMAL;
   assign srcBad  = srcWr && !armed && !srcConf && !srcValid;
   assign srcOk   = srcWr && !armed && !srcConf && srcValid;
   assign modeWr  = wrEn && awAddr_q == `TSS_A_MODE;
   assign modeOk  = modeWr && d[1:0] != 2'h3 && !d[2];

   // ----------------------------------------
   // selectors and mode
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         sel_q[0] <= '{kind: TSS_IMM, idx: `TSS_IDX_NONE};
         sel_q[1] <= '{kind: TSS_HOLD, idx: `TSS_IDX_NONE};
      end else if (modeOk && d[1:0] != TSS_NORMAL) begin
         sel_q[0] <= '{kind: TSS_LINE, idx: {d[4:3], 1'b1}};
      end else if (srcOk) begin
         sel_q[srcSel] <= newSrc;
      end
   end

   always_ff @(posedge clk) begin
      if (reset)
         mode_q <= TSS_NORMAL;
      else if (modeOk)
         mode_q <= tss_mode_t'(d[1:0]);
   end
   always_ff @(posedge clk) begin
      if (reset)
         qSel_q <= 1'b0;
      else if (srcWr)
         qSel_q <= srcSel;
   end
   logic [1:0]        slope_q;
   logic [NUM_CH-1:0] lower_q, upper_q, intClr;
   always_ff @(posedge clk) begin
      if (reset)
         slope_q <= `TSS_SLOPE_RST;
      else if (wrEn && awAddr_q == `TSS_A_SLOPE)
         slope_q <= d[1:0];
   end
   assign intClr = (srcOk && newSrc.kind == TSS_INT)
                   ? NUM_CH'(1) << (newSrc.idx - `TSS_IDX_ONE) : '0;
   always_ff @(posedge clk) begin
      if (reset) begin
         lower_q <= '0;
         upper_q <= '0;
      end else if (wrEn && awAddr_q == `TSS_A_LIMIT) begin
         lower_q <= d[NUM_CH-1:0];
         upper_q <= d[4+NUM_CH-1:4];
      end else begin
         lower_q <= lower_q & ~intClr;
         upper_q <= upper_q & ~intClr;
      end
   end

   // ----------------------------------------
   // trigger sources
   // ----------------------------------------
   logic              ext_q;
   logic [NUM_CH-1:0] above_q;
   logic [7:0]        line_q, riseAll, fallAll, lineFall;
   logic [1:0]        hit;
   logic              fire, trig_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_q   <= 1'b1;
         above_q <= '0;
         line_q  <= '1;
      end else begin
         ext_q   <= extTrigPin;
         above_q <= levelAbove;
         line_q  <= syncLineIn;
      end
   end

   assign riseAll  = 8'(levelAbove & ~above_q);
   assign fallAll  = 8'(~levelAbove & above_q);
   assign lineFall = line_q & ~syncLineIn;

   for (genvar g = 0; g < 2; g++) begin : gHit
      logic [2:0] ch;
      assign ch = sel_q[g].idx - `TSS_IDX_ONE;
      always_comb begin
         case (sel_q[g].kind)
            TSS_BUS:  hit[g] = busCmd;
            TSS_EXT:  hit[g] = ext_q && !extTrigPin;
            TSS_HOLD: hit[g] = 1'b0;
            TSS_IMM:  hit[g] = 1'b1;
            TSS_INT:  hit[g] = slope_q[g] ? riseAll[ch] : fallAll[ch];
            TSS_LINE: hit[g] = lineFall[sel_q[g].idx];
            default:  hit[g] = 1'b0;
         endcase
      end
   end

   assign fire = armed && (hit[0] || hit[1]);

   always_ff @(posedge clk) begin
      if (reset)
         state_q <= TSS_IDLE;
      else begin
         case (state_q)
            TSS_IDLE: if (cmd && d[`TSS_C_ARM]) state_q <= TSS_WAIT;
            TSS_WAIT: if (fire || (cmd && d[`TSS_C_ABORT])) state_q <= TSS_IDLE;
            default:  state_q <= TSS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset)
         trig_q <= 1'b0;
      else
         trig_q <= fire;
   end

   assign trigOut  = trig_q;
   assign armedOut = armed;

   // ----------------------------------------
   // errors, events, self test
   // ----------------------------------------
   logic [4:0]  err_q, errSet;
   logic [7:0]  evt_q, ese_q, stb;
   logic        oper_q, testRes_q;
   always_comb begin
      errSet = '0;
      errSet[`TSS_E_IGN]   = busCmd && !armed;
      errSet[`TSS_E_CONF]  = srcConf;
      errSet[`TSS_E_ARMD]  = srcArmd;
      errSet[`TSS_E_RANGE] = srcBad || (modeWr && !modeOk);
      errSet[`TSS_E_TEST]  = testCmd && selfTestFault;
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         err_q  <= '0;
         evt_q  <= '0;
         oper_q <= 1'b0;
      end else begin
         err_q  <= (clrCmd ? '0 : err_q) | errSet;
         evt_q  <= clrCmd ? '0 : evt_q;
         evt_q[`TSS_EV_DEV] <= (!clrCmd && evt_q[`TSS_EV_DEV]) || errSet[`TSS_E_TEST];
         evt_q[`TSS_EV_EXE] <= (!clrCmd && evt_q[`TSS_EV_EXE]) || |errSet[3:0];
         oper_q <= (!clrCmd && oper_q) || fire;
      end
   end

   always_ff @(posedge clk) begin
      if (reset)
         ese_q <= '0;
      else if (wrEn && awAddr_q == `TSS_A_ESE)
         ese_q <= d;
   end
   always_ff @(posedge clk) begin
      if (reset)
         testRes_q <= 1'b0;
      else if (testCmd)
         testRes_q <= selfTestFault;
   end
   always_comb begin
      stb = '0;
      stb[`TSS_SB_ERR]  = |err_q;
      stb[`TSS_SB_ESB]  = |(evt_q & ese_q);
      stb[`TSS_SB_OPER] = oper_q;
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   tss_src_t q;
   always_comb begin
      q        = sel_q[qSel_q];
      rdNext   = '0;
      rdMapped = 1'b1;
      if (q.kind == TSS_INT && q.idx == `TSS_IDX_ONE)
         q.idx = `TSS_IDX_NONE;
      case (s_axi_araddr)
         `TSS_A_CTRL:  rdNext[0] = armed;
         `TSS_A_SRC:   rdNext[7:0] = {qSel_q, 1'b0, q.idx, q.kind};
         `TSS_A_SLOPE: rdNext[1:0] = slope_q;
         `TSS_A_MODE:  rdNext[4:0] = {sel_q[0].idx[2:1], 1'b0, mode_q};
         `TSS_A_LIMIT: rdNext[7:0] = {4'(upper_q), 4'(lower_q)};
         `TSS_A_ERR:   rdNext[4:0] = err_q;
         `TSS_A_STAT:  rdNext[15:0] = {stb, evt_q};
         `TSS_A_ESE:   rdNext[7:0] = ese_q;
         `TSS_A_TEST:  rdNext[0] = testRes_q;
         default:      rdMapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= `TSS_RESP_OK;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdNext;
         rresp_q  <= rdMapped ? `TSS_RESP_OK : `TSS_RESP_ERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence sArmedImm;
      armed && (sel_q[0].kind == TSS_IMM || sel_q[1].kind == TSS_IMM);
   endsequence
   sequence sBothHold;
      sel_q[0].kind == TSS_HOLD && sel_q[1].kind == TSS_HOLD;
   endsequence

   a_fire_needs_arm: assert property (trig_q |-> $past(armed) && !armed)
      else $error("trigger without arming");
   a_imm_fires: assert property (sArmedImm |=> trig_q)
      else $error("instant source did not fire");
   a_ext_falling: assert property (armed && sel_q[0].kind == TSS_EXT
      && ext_q && !extTrigPin |=> trig_q)
      else $error("external edge missed");
   a_bus_ignored: assert property (busCmd && !armed |=> err_q[`TSS_E_IGN])
      else $error("ignored trigger not logged");
   a_hold_quiet: assert property (sBothHold ##1 sBothHold |-> !trig_q)
      else $error("hold source fired");
   a_sel1_locked: assert property (srcWr && !srcSel && mode_q != TSS_NORMAL
      && !modeWr && !armed |=> $stable(sel_q[0]) && err_q[`TSS_E_CONF])
      else $error("selector one changed in sync mode");
   a_sync_force: assert property (modeOk && d[1:0] != TSS_NORMAL
      |=> sel_q[0].kind == TSS_LINE && sel_q[0].idx == {$past(d[4:3]), 1'b1})
      else $error("selector one not forced to line");
   a_armed_refuse: assert property (srcWr && armed && !modeWr
      |=> $stable(sel_q[0]) && $stable(sel_q[1]) && err_q[`TSS_E_ARMD])
      else $error("source changed while armed");
   a_clear_mask: assert property (clrCmd |=> $stable(ese_q) && evt_q == '0
      || $past(|errSet))
      else $error("status clear broke masks");
endmodule : tss_trigger_select
`default_nettype wire
